/* core/prr_core.sv */
// peripheral pin routing unit: input/output selects, lock and two-wire buffers
//
// How it works
// - input select codes 0x00-0x05 pick port a bits 0-5 and 0x10-0x15 port c bits 0-5.
// - power-on reset loads every select with its default and removes the permanent lock.
// - other device resets keep every input and output select as it is.
// - two-wire signals on other pins use that pin's ttl or schmitt buffer.
// - two-wire mode on the dedicated pins forces the two-wire thresholds.
// - while the lock flag is set, writes to all select registers are ignored.
// - the lock flag changes only on the write right after 0x55 then 0xAA.
// - with the one-way option the flag may be cleared once and set once per reset.
// - with the one-way option a set after the single clear sticks until reset.
// - sleep leaves every select untouched.
// - each peripheral input has its own select, all with the same pin coding.
// - each pin has an output source select; direction control owns the driver unless the selected source owns its direction
`timescale 1ns/10ps
`default_nettype none
module prr_core
    import prr_pkg::*;
(
    input  wire logic                               clk,
    input  wire logic                               nrst,
    input  wire logic                               dev_rst,
    input  wire logic                               sleep_i,
    input  wire logic                               one_way_lock_option,
    input  wire logic                               two_wire_mode,
    input  wire prr_pkg::prr_wr_t                   wr_i,
    input  wire prr_pkg::prr_port_t                 port_i,
    input  wire logic [prr_pkg::NUM_PIN-1:0]        pin_in,
    input  wire logic [prr_pkg::NUM_SRC-1:0]        src_out,
    input  wire logic [prr_pkg::NUM_SRC-1:0]        src_owns_dir,
    input  wire logic [prr_pkg::NUM_SRC-1:0]        src_oe_n,
    output logic [prr_pkg::NUM_IN-1:0]              periph_in,
    output logic [prr_pkg::NUM_PIN-1:0]             pin_out,
    output logic [prr_pkg::NUM_PIN-1:0]             pin_oe_n,
    output logic [prr_pkg::NUM_PIN-1:0]             pin_thr_st,
    output logic [prr_pkg::NUM_PIN-1:0]             pin_thr_tw,
    output logic                                    selection_lock_flag,
    output logic [prr_pkg::NUM_IN-1:0][4:0]         in_sel_rd,
    output logic [prr_pkg::NUM_PIN-1:0][4:0]        out_sel_rd
);
    import prr_pkg::*;

    typedef struct packed {
        logic [NUM_IN-1:0][SEL_W-1:0]  in_sel;
        logic [NUM_PIN-1:0][SEL_W-1:0] out_sel;
        logic                          lock;
        logic                          clr_used;
        logic                          set_used;
        prr_seq_t                      seq;
        logic [NUM_PIN-1:0]            s1;
        logic [NUM_PIN-1:0]            s2;
        logic [NUM_PIN-1:0]            s3;
        logic [NUM_PIN-1:0]            filt;
        logic [NUM_IN-1:0]             pin_to_periph;
        logic [NUM_PIN-1:0]            drv;
        logic [NUM_PIN-1:0]            oe_n;
        logic [NUM_PIN-1:0]            thr_st;
        logic [NUM_PIN-1:0]            thr_tw;
    } prr_state_t;

    prr_state_t st_reg;
    prr_state_t st_next;

    // turns an input select code into a pin index, invalid codes flagged
    function automatic logic [PIN_IDX_W:0] pin_decode(input logic [SEL_W-1:0] code);
        logic [PIN_IDX_W:0] r;
        r = '0;
        if (code <= CODE_PA_HI)
            r = {1'b1, code[3:0]};
        else if (LARGE_VARIANT && code >= CODE_PC_LO && code <= CODE_PC_HI)
            r = {1'b1, PC_BASE + code[3:0]};
        return r;
    endfunction

    logic wr_in;
    logic wr_out;
    logic wr_lock;
    logic lock_req;
    logic [PIN_IDX_W:0] dec;

    assign wr_in   = wr_i.en && wr_i.tgt == PRR_TGT_IN  && wr_i.idx < 5'(NUM_IN);
    assign wr_out  = wr_i.en && wr_i.tgt == PRR_TGT_OUT && wr_i.idx < 5'(NUM_PIN);
    assign wr_lock = wr_i.en && wr_i.tgt == PRR_TGT_LOCK;
    assign lock_req = wr_i.data[LOCK_BIT];

    // next-state logic; sleep_i is deliberately not read by anything in this block
    // sleep ignored
    always_comb
    begin
        st_next = st_reg;
        dec = '0;
        // pin synchroniser, s1 feeds only s2
        st_next.s1 = pin_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int p = 0; p < NUM_PIN; p++)
        begin
            if (st_reg.s2[p] == st_reg.s3[p])
                st_next.filt[p] = st_reg.s3[p];
        end
        if (!st_reg.lock && wr_in)
            st_next.in_sel[wr_i.idx] = wr_i.data[SEL_W-1:0];
        if (!st_reg.lock && wr_out)
            st_next.out_sel[wr_i.idx[3:0]] = wr_i.data[SEL_W-1:0];
        case (st_reg.seq)
            PRR_SEQ_IDLE:
                if (wr_lock && wr_i.data == UNLOCK_KEY1)
                    st_next.seq = PRR_SEQ_KEY1;
            PRR_SEQ_KEY1:
                if (wr_i.en)
                    st_next.seq = (wr_lock && wr_i.data == UNLOCK_KEY2) ?
                                  PRR_SEQ_ARM : PRR_SEQ_IDLE;
            PRR_SEQ_ARM:
                if (wr_i.en)
                begin
                    st_next.seq = PRR_SEQ_IDLE;
                    if (wr_lock && lock_req != st_reg.lock)
                    begin
                        if (!lock_req && !(one_way_lock_option && st_reg.clr_used))
                        begin
                            st_next.lock = 1'b0;
                            st_next.clr_used = 1'b1;
                        end
                        else if (lock_req && !(one_way_lock_option && st_reg.set_used))
                        begin
                            st_next.lock = 1'b1;
                            st_next.set_used = 1'b1;
                        end
                    end
                end
            default:
                st_next.seq = PRR_SEQ_IDLE;
        endcase
        // other resets keep selects, renew the one-way budget and cancel the key sequence
        if (dev_rst)
        begin
            st_next.seq = PRR_SEQ_IDLE;
            st_next.clr_used = 1'b0;
            st_next.set_used = 1'b0;
        end
        for (int i = 0; i < NUM_IN; i++)
        begin
            dec = pin_decode(st_reg.in_sel[i]);
            st_next.pin_to_periph[i] = dec[PIN_IDX_W] & st_reg.filt[dec[PIN_IDX_W-1:0]];
        end
        for (int p = 0; p < NUM_PIN; p++)
        begin
            if (st_reg.out_sel[p] == OUT_SEL_RST)
                st_next.drv[p] = port_i.lat[p];
            else
                st_next.drv[p] = src_out[st_reg.out_sel[p]];
            if (src_owns_dir[st_reg.out_sel[p]])
                st_next.oe_n[p] = src_oe_n[st_reg.out_sel[p]];
            else
                st_next.oe_n[p] = port_i.dir_in[p];
        end
        for (int p = 0; p < NUM_PIN; p++)
        begin
            st_next.thr_tw[p] = two_wire_mode && LARGE_VARIANT &&
                                (4'(p) == TW_CLK_PIN || 4'(p) == TW_DAT_PIN);
            st_next.thr_st[p] = port_i.thr_st[p] && !st_next.thr_tw[p];
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_reg <= '0;
            st_reg.in_sel <= IN_SEL_RST;
            st_reg.out_sel <= {NUM_PIN{OUT_SEL_RST}};
            st_reg.seq <= PRR_SEQ_IDLE;
            st_reg.oe_n <= '1;    // pins stay undriven until configured
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign periph_in           = st_reg.pin_to_periph;
    assign pin_out             = st_reg.drv;
    assign pin_oe_n            = st_reg.oe_n;
    assign pin_thr_st          = st_reg.thr_st;
    assign pin_thr_tw          = st_reg.thr_tw;
    assign selection_lock_flag = st_reg.lock;
    assign in_sel_rd           = st_reg.in_sel;
    assign out_sel_rd          = st_reg.out_sel;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_locked_hold;
        st_reg.lock && (wr_in || wr_out) |=> $stable(st_reg.in_sel) && $stable(st_reg.out_sel);
    endproperty
    a_locked_hold: assert property (p_locked_hold)
        else $error("select changed while locked");

    property p_unlocked_write;
        !st_reg.lock && wr_in |=> st_reg.in_sel[$past(wr_i.idx)] == $past(wr_i.data[4:0]);
    endproperty
    a_unlocked_write: assert property (p_unlocked_write)
        else $error("input select write lost");

    property p_no_seq_no_change;
        st_reg.seq != PRR_SEQ_ARM |=> $stable(st_reg.lock);
    endproperty
    a_no_seq_no_change: assert property (p_no_seq_no_change)
        else $error("lock flag changed without key sequence");

    property p_unlock_seq;
        (wr_lock && wr_i.data == UNLOCK_KEY1 && st_reg.seq == PRR_SEQ_IDLE && !dev_rst)
        ##1 (wr_lock && wr_i.data == UNLOCK_KEY2 && !dev_rst)
        ##1 (wr_lock && !wr_i.data[0] && !one_way_lock_option && !dev_rst)
        |=> !st_reg.lock;
    endproperty
    a_unlock_seq: assert property (p_unlock_seq)
        else $error("key sequence did not clear the flag");

    property p_stray_cancels;
        st_reg.seq == PRR_SEQ_KEY1 && wr_i.en && !wr_lock ##1 1'b1
        |-> st_reg.seq == PRR_SEQ_IDLE ##1 $stable(st_reg.lock);
    endproperty
    a_stray_cancels: assert property (p_stray_cancels)
        else $error("stray write did not cancel the sequence");

    property p_one_way_stick;
        one_way_lock_option && st_reg.lock && st_reg.clr_used && st_reg.set_used && !dev_rst
        |=> st_reg.lock;
    endproperty
    a_one_way_stick: assert property (p_one_way_stick)
        else $error("permanent lock was cleared");

    property p_keep_on_reset;
        (dev_rst || sleep_i) && !wr_in && !wr_out
        |=> $stable(st_reg.in_sel) && $stable(st_reg.out_sel);
    endproperty
    a_keep_on_reset: assert property (p_keep_on_reset)
        else $error("selects changed by reset or sleep");

    property p_route_in;
        $stable(st_reg.in_sel[0]) && st_reg.in_sel[0] == CODE_PA_LO
        |=> periph_in[0] == $past(st_reg.filt[0]);
    endproperty
    a_route_in: assert property (p_route_in)
        else $error("input routing mismatch");

    property p_tw_thresh;
        two_wire_mode |=> pin_thr_tw[TW_CLK_PIN] && !pin_thr_st[TW_CLK_PIN] && !pin_thr_tw[0];
    endproperty
    a_tw_thresh: assert property (p_tw_thresh)
        else $error("two-wire thresholds not applied");

    property p_armed_stray;
        st_reg.seq == PRR_SEQ_ARM && wr_i.en && !wr_lock
        |=> st_reg.seq == PRR_SEQ_IDLE && $stable(st_reg.lock);
    endproperty
    a_armed_stray: assert property (p_armed_stray)
        else $error("stray write after both keys did not cancel");

    property p_one_way_set_once;
        one_way_lock_option && st_reg.set_used && !st_reg.lock && !dev_rst |=> !st_reg.lock;
    endproperty
    a_one_way_set_once: assert property (p_one_way_set_once)
        else $error("second set accepted under the one-way option");

    property p_out_dir;
        !src_owns_dir[st_reg.out_sel[2]] |=> pin_oe_n[2] == $past(port_i.dir_in[2]);
    endproperty
    a_out_dir: assert property (p_out_dir)
        else $error("direction control lost the pin driver");

    property p_gen_buffer;
        1'b1 |=> pin_thr_st[5:0] == $past(port_i.thr_st[5:0])
            && pin_thr_st[11:8] == $past(port_i.thr_st[11:8]);
    endproperty
    a_gen_buffer: assert property (p_gen_buffer)
        else $error("general input buffer not used off the two-wire pins");

    property p_sleep_keep;
        sleep_i && !wr_i.en
        |=> $stable(st_reg.in_sel) && $stable(st_reg.out_sel) && $stable(st_reg.lock);
    endproperty
    a_sleep_keep: assert property (p_sleep_keep)
        else $error("selects changed across sleep");

    c_unlock: cover property (st_reg.seq == PRR_SEQ_ARM ##1 !st_reg.lock);
    c_lock:   cover property ($rose(st_reg.lock));
    c_stuck:  cover property (one_way_lock_option && st_reg.clr_used && st_reg.set_used);
    c_cancel: cover property (st_reg.seq == PRR_SEQ_KEY1 ##1 st_reg.seq == PRR_SEQ_IDLE);
endmodule : prr_core // prr_core
`default_nettype wire

/* core/prr_pkg.sv */
// shared constants and types of the peripheral pin routing unit
package prr_pkg;
    localparam int          NUM_IN      = 18;   // peripheral inputs with a select each
    localparam int          NUM_PIN     = 12;   // port a bits 0..5, port c bits 0..5
    localparam int          NUM_SRC     = 32;   // output source codes
    localparam int          SEL_W       = 5;
    localparam int          PIN_IDX_W   = 4;
    localparam logic        LARGE_VARIANT = 1'b1;
    // pin codes
    localparam logic [4:0]  CODE_PA_LO  = 5'h00;
    localparam logic [4:0]  CODE_PA_HI  = 5'h05;
    localparam logic [4:0]  CODE_PC_LO  = 5'h10;
    localparam logic [4:0]  CODE_PC_HI  = 5'h15;
    localparam logic [3:0]  PC_BASE     = 4'h6;  // pin index of port c bit 0
    // dedicated two-wire pins
    localparam logic [3:0]  TW_CLK_PIN  = 4'h6;
    localparam logic [3:0]  TW_DAT_PIN  = 4'h7;
    // lock control register
    localparam logic [7:0]  UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0]  UNLOCK_KEY2 = 8'hAA;
    localparam int          LOCK_BIT    = 0;
    // power-on defaults, index 0 is the external interrupt input
    localparam logic [NUM_IN-1:0][SEL_W-1:0] IN_SEL_RST = {
        5'h14, 5'h15, 5'h13, 5'h11, 5'h10, 5'h12, 5'h05, 5'h11, 5'h14,
        5'h13, 5'h02, 5'h13, 5'h15, 5'h05, 5'h04, 5'h05, 5'h02, 5'h02};
    localparam logic [SEL_W-1:0] OUT_SEL_RST = 5'h00;  // code 0: port latch

    typedef enum logic [1:0] {
        PRR_TGT_IN   = 2'h0,
        PRR_TGT_OUT  = 2'h1,
        PRR_TGT_LOCK = 2'h2
    } prr_tgt_t;

    // gray order along idle, first key, armed
    typedef enum logic [1:0] {
        PRR_SEQ_IDLE = 2'h0,
        PRR_SEQ_KEY1 = 2'h1,
        PRR_SEQ_ARM  = 2'h3
    } prr_seq_t;

    typedef struct packed {
        logic       en;
        prr_tgt_t   tgt;
        logic [4:0] idx;
        logic [7:0] data;
    } prr_wr_t;

    typedef struct packed {
        logic [NUM_PIN-1:0] lat;       // port latch values
        logic [NUM_PIN-1:0] dir_in;    // direction control, 1 = input
        logic [NUM_PIN-1:0] thr_st;    // input threshold select, 1 = schmitt
    } prr_port_t;
endpackage : prr_pkg

/* sim/prr_core_bench.sv */
// self-checking bench of the peripheral pin routing unit
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module prr_core_bench;
    import prr_pkg::*;
    logic                    clk, nrst, dev_rst, sleep_i, one_way_lock_option, two_wire_mode;
    prr_wr_t                 wr_i;
    prr_port_t               port_i;
    logic [NUM_PIN-1:0]      pin_in, pin_out, pin_oe_n, pin_thr_st, pin_thr_tw;
    logic [NUM_SRC-1:0]      src_out, src_owns_dir, src_oe_n;
    logic [NUM_IN-1:0]       periph_in;
    logic                    selection_lock_flag;
    logic [NUM_IN-1:0][4:0]  in_sel_rd;
    logic [NUM_PIN-1:0][4:0] out_sel_rd;
    int                      errors;
    int                      samples_checked;

    prr_core dut (.clk(clk), .nrst(nrst), .dev_rst(dev_rst), .sleep_i(sleep_i),
        .one_way_lock_option(one_way_lock_option), .two_wire_mode(two_wire_mode),
        .wr_i(wr_i), .port_i(port_i), .pin_in(pin_in), .src_out(src_out),
        .src_owns_dir(src_owns_dir), .src_oe_n(src_oe_n), .periph_in(periph_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_thr_st(pin_thr_st),
        .pin_thr_tw(pin_thr_tw), .selection_lock_flag(selection_lock_flag),
        .in_sel_rd(in_sel_rd), .out_sel_rd(out_sel_rd));

    // 40 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // inputs always move 1 ns after the edge so no race with the sampling edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // one write, then an idle cycle so routing outputs have landed on return
    task automatic wr(input prr_tgt_t tgt, input logic [4:0] idx, input logic [7:0] data);
        wr_i = '{en: 1'b1, tgt: tgt, idx: idx, data: data};
        step(1);
        wr_i.en = 1'b0;
        step(1);
    endtask

    // key pair then the flag write
    // three writes back to back, strobe held high
    task automatic lock_seq(input logic [7:0] last);
        wr_i = '{en: 1'b1, tgt: PRR_TGT_LOCK, idx: 5'h00, data: UNLOCK_KEY1};
        step(1);
        wr_i.data = UNLOCK_KEY2;
        step(1);
        wr_i.data = last;
        step(1);
        wr_i.en = 1'b0;
        step(1);
    endtask

    task automatic pulse_dev_rst();
        dev_rst = 1'b1;
        step(1);
        dev_rst = 1'b0;
        step(1);
    endtask

    task automatic t_reset();
        `CHK(in_sel_rd, IN_SEL_RST)
        `CHK(in_sel_rd[5], 5'h15)
        `CHK(out_sel_rd, {NUM_PIN{OUT_SEL_RST}})
        `CHK(selection_lock_flag, 1'b0)
    endtask

    // every pin code on one input; pin index equals loop index
    task automatic t_in_route();
        logic [4:0] code;
        for (int k = 0; k < 12; k++)
        begin
            code = (k < 6) ? 5'(k) : 5'(k + 10);
            wr(PRR_TGT_IN, 5'h00, {3'h0, code});
            `CHK(in_sel_rd[0], code)
            pin_in = 12'h001 << k;
            step(8);
            `CHK(periph_in[0], 1'b1)
            pin_in = ~(12'h001 << k);
            step(8);
            `CHK(periph_in[0], 1'b0)
        end
        wr(PRR_TGT_IN, 5'h11, 8'h13);
        pin_in = 12'h200;
        step(8);
        `CHK(periph_in[17], 1'b1)
        `CHK(periph_in[0], 1'b0)
    endtask

    task automatic t_out_route();
        port_i.dir_in = 12'hFFB;
        port_i.lat = 12'h004;
        wr(PRR_TGT_OUT, 5'h02, 8'h00);
        `CHK(pin_out[2], 1'b1)
        `CHK(pin_oe_n[2], 1'b0)
        wr(PRR_TGT_OUT, 5'h02, 8'h09);
        `CHK(out_sel_rd[2], 5'h09)
        `CHK(pin_out[2], 1'b0)
        src_out[9] = 1'b1;
        step(2);
        `CHK(pin_out[2], 1'b1)
        port_i.dir_in = 12'hFFF;
        step(2);
        `CHK(pin_oe_n[2], 1'b1)
        // peripheral that owns its direction overrides the direction control
        src_owns_dir[9] = 1'b1;
        step(2);
        `CHK(pin_oe_n[2], 1'b0)
        src_owns_dir[9] = 1'b0;
    endtask

    task automatic t_lock();
        lock_seq(8'h01);
        `CHK(selection_lock_flag, 1'b1)
        wr(PRR_TGT_IN, 5'h01, 8'h05);
        `CHK(in_sel_rd[1], IN_SEL_RST[1])
        wr(PRR_TGT_OUT, 5'h03, 8'h01);
        `CHK(out_sel_rd[3], 5'h00)
        wr(PRR_TGT_LOCK, 5'h00, 8'h00);
        `CHK(selection_lock_flag, 1'b1)
        wr(PRR_TGT_LOCK, 5'h00, UNLOCK_KEY1);
        wr(PRR_TGT_IN, 5'h01, 8'h05);
        wr(PRR_TGT_LOCK, 5'h00, UNLOCK_KEY2);
        wr(PRR_TGT_LOCK, 5'h00, 8'h00);
        `CHK(selection_lock_flag, 1'b1)
        wr(PRR_TGT_LOCK, 5'h00, UNLOCK_KEY1);
        wr(PRR_TGT_LOCK, 5'h00, UNLOCK_KEY2);
        wr(PRR_TGT_OUT, 5'h03, 8'h01);
        wr(PRR_TGT_LOCK, 5'h00, 8'h00);
        `CHK(selection_lock_flag, 1'b1)
        `CHK(out_sel_rd[3], 5'h00)
        lock_seq(8'h00);
        `CHK(selection_lock_flag, 1'b0)
        wr(PRR_TGT_IN, 5'h01, 8'h05);
        `CHK(in_sel_rd[1], 5'h05)
    endtask

    // clock function moved off its dedicated pin, data left on pin 7
    task automatic t_two_wire();
        port_i.thr_st = 12'h0F4;
        wr(PRR_TGT_IN, 5'h0D, 8'h02);
        `CHK(in_sel_rd[14], 5'h11)
        `CHK(pin_thr_st, 12'h0F4)
        `CHK(pin_thr_tw, 12'h000)
        // data input and output share pin 7, the peripheral owns the driver
        wr(PRR_TGT_OUT, 5'h07, 8'h16);
        src_owns_dir[22] = 1'b1;
        src_out[22] = 1'b1;
        pin_in = 12'h084;
        step(8);
        `CHK(out_sel_rd[7], 5'h16)
        `CHK(pin_oe_n[7], 1'b0)
        `CHK(pin_out[7], 1'b1)
        `CHK(periph_in[14], 1'b1)
        `CHK(periph_in[13], 1'b1)
        two_wire_mode = 1'b1;
        step(2);
        `CHK(pin_thr_tw[7], 1'b1)
        `CHK(pin_thr_st[7:6], 2'h0)
        `CHK(pin_thr_tw[5:0], 6'h00)
        `CHK(pin_thr_st[5:0], 6'h34)
        two_wire_mode = 1'b0;
        src_owns_dir[22] = 1'b0;
    endtask

    task automatic t_resets();
        sleep_i = 1'b1;
        step(3);
        sleep_i = 1'b0;
        step(1);
        `CHK(in_sel_rd[1], 5'h05)
        lock_seq(8'h01);
        pulse_dev_rst();
        `CHK(in_sel_rd[1], 5'h05)
        `CHK(out_sel_rd[2], 5'h09)
        `CHK(selection_lock_flag, 1'b1)
    endtask

    task automatic t_one_way();
        one_way_lock_option = 1'b1;
        pulse_dev_rst();
        lock_seq(8'h00);
        `CHK(selection_lock_flag, 1'b0)
        wr(PRR_TGT_IN, 5'h02, 8'h03);
        `CHK(in_sel_rd[2], 5'h03)
        lock_seq(8'h01);
        `CHK(selection_lock_flag, 1'b1)
        lock_seq(8'h00);
        `CHK(selection_lock_flag, 1'b1)
        nrst = 1'b0;
        step(2);
        nrst = 1'b1;
        step(1);
        `CHK(selection_lock_flag, 1'b0)
        `CHK(in_sel_rd, IN_SEL_RST)
        `CHK(out_sel_rd, {NUM_PIN{OUT_SEL_RST}})
        // after power-on the set comes first, then the one clear
        lock_seq(8'h01);
        `CHK(selection_lock_flag, 1'b1)
        lock_seq(8'h00);
        `CHK(selection_lock_flag, 1'b0)
        lock_seq(8'h01);
        `CHK(selection_lock_flag, 1'b0)
        // a device reset renews the single set
        pulse_dev_rst();
        lock_seq(8'h01);
        `CHK(selection_lock_flag, 1'b1)
    endtask

    task automatic wrap_up();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // main sequence: reset for 4 cycles, then the scenarios in order
    initial
    begin
        errors = 0;
        samples_checked = 0;
        {dev_rst, sleep_i, one_way_lock_option, two_wire_mode} = 4'h0;
        wr_i = '0;
        port_i = '{lat: 12'h000, dir_in: 12'hFFF, thr_st: 12'h000};
        pin_in = 12'h000;
        {src_out, src_owns_dir, src_oe_n} = {32'h0, 32'h0, 32'h0};
        nrst = 1'b0;
        step(4);
        nrst = 1'b1;
        step(1);
        t_reset();
        t_in_route();
        t_out_route();
        t_lock();
        t_two_wire();
        t_resets();
        t_one_way();
        wrap_up();
    end

    // watchdog, generous against the roughly 330 cycles the run needs
    initial
    begin
        #(25 * 5000);
        errors++;
        wrap_up();
    end
endmodule // prr_core_bench
`default_nettype wire
